// ---- bench/ucr_channel_regs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module ucr_channel_regs_tb;
    logic                   sys_clk_i;
    logic                   srst_i;
    logic                   cts_lvl;
    ucr_pkg::ucr_host_req_t rq;
    ucr_pkg::ucr_engine_t   eng;
    ucr_pkg::ucr_ctrl_t     ctrl;
    logic [7:0]             rdat;
    logic [7:0]             txd;
    logic                   rvld;
    logic                   txl;
    logic                   rxt;
    logic                   rxr;
    logic                   txr;
    logic                   tick;
    int                     err_total;
    int                     n_compared;
    int                     nt;

    ucr_engine_model u_ucr_engine_model (.cts_i(cts_lvl), .engine_o(eng));

    ucr_channel_regs u_ucr_channel_regs (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .host_req_i(rq), .engine_i(eng),
        .rd_data_o(rdat), .rd_valid_o(rvld), .ctrl_o(ctrl), .tx_load_o(txl),
        .tx_data_o(txd), .rx_take_o(rxt), .rx_fifo_reset_o(rxr),
        .tx_fifo_reset_o(txr), .baud_tick_o(tick)
    );

    initial
    begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // ****************************************************************
    // host access tasks
    // ****************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    // strobes last one cycle; next access waits a fresh edge
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        rq <= '{cs: 1'b1, chan: 1'b0, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge sys_clk_i);
        rq <= '0;
        #1;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rq <= '{cs: 1'b1, chan: 1'b0, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge sys_clk_i);
        rq <= '0;
        #1;
        chk({7'h00, rvld}, 8'h01);
        chk(rdat, e);
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        rq = '0;
        srst_i = 1'b1;
        cts_lvl = 1'b0;
        err_total = 0;
        n_compared = 0;
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd_chk(3'h1, 8'h00);
        rd_chk(3'h2, 8'h01);
        rd_chk(3'h3, 8'h00);
        rd_chk(3'h4, 8'h00);
        rd_chk(3'h5, 8'h60);
        rd_chk(3'h7, 8'hff);
        chk(ctrl.enhanced_mode_select, 8'h80);
        wr_reg(3'h5, 8'h12);
        rd_chk(3'h5, 8'h60);
        wr_reg(3'h0, 8'ha5);
        chk({txl, txd[6:0]}, 8'ha5);
        rd_chk(3'h0, 8'h3c);
        chk({7'h00, rxt}, 8'h01);
        wr_reg(3'h2, 8'h07);
        chk({ctrl.fifo_control[5:0], rxr, txr}, 8'h07);
        rd_chk(3'h2, 8'hc1);
        // gate still closed: upper enable bits must read back as zero
        wr_reg(3'h1, 8'hff);
        rd_chk(3'h1, 8'h0f);
        wr_reg(3'h3, 8'h80);
        rd_chk(3'h0, 8'h5c);
        rd_chk(3'h1, 8'h3e);
        rd_chk(3'h2, 8'h00);
        wr_reg(3'h2, 8'h05);
        rd_chk(3'h2, 8'h05);
        wr_reg(3'h0, 8'h03);
        wr_reg(3'h1, 8'h00);
        rd_chk(3'h0, 8'h03);
        rd_chk(3'h1, 8'h00);
        nt = 0;
        repeat (30)
        begin
            @(posedge sys_clk_i);
            #1;
            if (tick === 1'b1)
                nt++;
        end
        chk(nt[7:0], 8'h0a);
        // shortest even divisor: one tick every second clock
        wr_reg(3'h0, 8'h02);
        nt = 0;
        repeat (30)
        begin
            @(posedge sys_clk_i);
            #1;
            if (tick === 1'b1)
                nt++;
        end
        chk(nt[7:0], 8'h0f);
        wr_reg(3'h3, 8'hbf);
        rd_chk(3'h3, 8'hbf);
        rd_chk(3'h0, 8'h07);
        wr_reg(3'h0, 8'h22);
        chk(ctrl.trigger_level_set, 8'h22);
        wr_reg(3'h1, 8'h40);
        rd_chk(3'h1, 8'h40);
        rd_chk(3'h2, 8'h00);
        wr_reg(3'h2, 8'h10);
        rd_chk(3'h2, 8'h10);
        for (int i = 4; i < 8; i++)
        begin
            rd_chk(i[2:0], 8'h00);
            wr_reg(i[2:0], 8'h80 + i[7:0]);
            rd_chk(i[2:0], 8'h80 + i[7:0]);
        end
        wr_reg(3'h3, 8'h00);
        wr_reg(3'h1, 8'ha5);
        rd_chk(3'h1, 8'ha5);
        rd_chk(3'h7, 8'h07);
        wr_reg(3'h7, 8'h3b);
        chk(ctrl.enhanced_mode_select, 8'h3b);
        @(posedge sys_clk_i);
        cts_lvl <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rd_chk(3'h6, 8'h11);
        rd_chk(3'h6, 8'h10);
        report_and_stop;
    end
endmodule

`default_nettype wire

// ---- bench/ucr_engine_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// serial engine stand-in
// ****************************************************************
// static engine state keeps read expectations fixed; only cts moves
module ucr_engine_model (
    input  wire logic             cts_i,
    output ucr_pkg::ucr_engine_t  engine_o
);
    assign engine_o = '{rx_data: 8'h3c, line_status: 8'h60, fifo_level: 8'h07,
                        int_code: 6'h01, cts: cts_i, dsr: 1'b0, ri: 1'b0, cd: 1'b0};
endmodule

`default_nettype wire

// ---- design/ucr_cfg.svh ----
`ifndef UCR_CFG_SVH
`define UCR_CFG_SVH

// ****************************************************************
// register locations on the three address lines
// ****************************************************************
`define UCR_A_DATA      3'h0
`define UCR_A_IER       3'h1
`define UCR_A_ISR       3'h2
`define UCR_A_LCR       3'h3
`define UCR_A_MCR       3'h4
`define UCR_A_LSR       3'h5
`define UCR_A_MSR       3'h6
`define UCR_A_SPR       3'h7

// ****************************************************************
// mode keys and field positions
// ****************************************************************
`define UCR_ENH_KEY     8'hbf
`define UCR_LCR_DIV_BIT 7
`define UCR_EFR_GATE    4
`define UCR_FEATURE_CONTROL_SWAP   6
`define UCR_FCR_EN      0
`define UCR_FCR_RXRST   1
`define UCR_FCR_TXRST   2
`define UCR_FCR_SELFCLR 8'h06

// ****************************************************************
// gated (enhanced) bit masks
// ****************************************************************
`define UCR_GATE_IER    8'hf0
`define UCR_GATE_ISR    8'h30
`define UCR_GATE_FCR    8'h30
`define UCR_GATE_MCR    8'he0

// ****************************************************************
// reset values
// ****************************************************************
`define UCR_RST_ZERO    8'h00
`define UCR_RST_ISR     8'h01
`define UCR_RST_LSR     8'h60
`define UCR_RST_SPR     8'hff
`define UCR_RST_ENHANCED_MODE_SELECT    8'h80

`endif

// ---- design/ucr_channel_regs.sv ----
`include "ucr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ucr_channel_regs #(
    parameter logic       CHANNEL_ID  = 1'b0,
    parameter logic [7:0] REVISION_ID = 8'h5c,  // arbitrary value
    parameter logic [7:0] DEVICE_ID   = 8'h3e   // arbitrary value
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  srst_i,
    input  wire ucr_pkg::ucr_host_req_t host_req_i,
    input  wire ucr_pkg::ucr_engine_t  engine_i,
    output logic [7:0]                 rd_data_o,
    output logic                       rd_valid_o,
    output ucr_pkg::ucr_ctrl_t         ctrl_o,
    output logic                       tx_load_o,
    output logic [7:0]                 tx_data_o,
    output logic                       rx_take_o,
    output logic                       rx_fifo_reset_o,
    output logic                       tx_fifo_reset_o,
    output logic                       baud_tick_o
);

    // ****************************************************************
    // decode
    // ****************************************************************
    ucr_pkg::ucr_ctrl_t ctrl_r;
    ucr_pkg::ucr_mode_t mode;
    logic [7:0]         spr_r;
    logic [7:0]         lsr_r;
    logic [7:0]         isr_r;
    logic [7:0]         lvl_r;
    logic [3:0]         msr_prev_r;
    logic [3:0]         msr_delta_r;
    logic               msr_primed_r;
    logic [7:0]         rd_data_r;
    logic               rd_valid_r;
    logic               tx_load_r;
    logic [7:0]         tx_data_r;
    logic               rx_take_r;
    logic               rx_fifo_reset_r;
    logic               tx_fifo_reset_r;
    logic [15:0]        baud_cnt_r;
    logic               baud_tick_r;
    logic               acc;
    logic               wr;
    logic               rd;
    logic [2:0]         addr;
    logic [7:0]         wdata;
    logic               gate_open;
    logic               div_zero;
    logic [15:0]        div_word;
    logic [3:0]         msr_now;
    logic [7:0]         rd_mux;

    assign acc       = host_req_i.cs && (host_req_i.chan == CHANNEL_ID);
    assign wr        = acc && host_req_i.wr;
    assign rd        = acc && host_req_i.rd;
    assign addr      = host_req_i.addr;
    assign wdata     = host_req_i.wdata;
    assign gate_open = ctrl_r.enhanced_function[`UCR_EFR_GATE];
    assign div_word  = {ctrl_r.divisor_high, ctrl_r.dll};
    assign div_zero  = (div_word == 16'h0000);
    assign msr_now   = {engine_i.cd, engine_i.ri, engine_i.dsr, engine_i.cts};

    always_comb
    begin
        if (ctrl_r.line_control == `UCR_ENH_KEY)
            mode = ucr_pkg::ucr_mode_enhanced;
        else if (ctrl_r.line_control[`UCR_LCR_DIV_BIT])
            mode = ucr_pkg::ucr_mode_divisor;
        else
            mode = ucr_pkg::ucr_mode_normal;
    end

    // gated bits read as zero while the gate is shut
    function automatic logic [7:0] ucr_mask(input logic [7:0] v, input logic [7:0] m,
                                            input logic open);
        return open ? v : (v & ~m);
    endfunction

    // gated bits keep their stored value when a write arrives with the gate shut
    function automatic logic [7:0] ucr_merge(input logic [7:0] old, input logic [7:0] nw,
                                             input logic [7:0] m, input logic open);
        return open ? nw : ((nw & ~m) | (old & m));
    endfunction

    // ****************************************************************
    // register writes
    // ****************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            ctrl_r      <= '0;
            ctrl_r.enhanced_mode_select <= `UCR_RST_ENHANCED_MODE_SELECT;
            spr_r       <= `UCR_RST_SPR;
        end
        else if (wr)
        begin
            case (addr)
                `UCR_A_DATA:
                begin
                    if (mode == ucr_pkg::ucr_mode_enhanced)
                        ctrl_r.trigger_level_set <= wdata;
                    else if (mode == ucr_pkg::ucr_mode_divisor)
                        ctrl_r.dll <= wdata;
                end
                `UCR_A_IER:
                begin
                    if (mode == ucr_pkg::ucr_mode_enhanced)
                        ctrl_r.feature_control <= wdata;
                    else if (mode == ucr_pkg::ucr_mode_divisor)
                        ctrl_r.divisor_high <= wdata;
                    else
                        ctrl_r.interrupt_enable <= ucr_merge(ctrl_r.interrupt_enable, wdata, `UCR_GATE_IER,
                                                gate_open);
                end
                `UCR_A_ISR:
                begin
                    if (mode == ucr_pkg::ucr_mode_enhanced)
                        ctrl_r.enhanced_function <= wdata;
                    else if (mode == ucr_pkg::ucr_mode_divisor)
                        ctrl_r.alt_function <= wdata;
                    else
                        ctrl_r.fifo_control <= ucr_merge(ctrl_r.fifo_control, wdata & ~`UCR_FCR_SELFCLR,
                                                `UCR_GATE_FCR, gate_open);
                end
                `UCR_A_LCR:
                    ctrl_r.line_control <= wdata;
                `UCR_A_MCR:
                begin
                    if (mode == ucr_pkg::ucr_mode_enhanced)
                        ctrl_r.xon1 <= wdata;
                    else
                        ctrl_r.modem_control <= ucr_merge(ctrl_r.modem_control, wdata, `UCR_GATE_MCR,
                                                gate_open);
                end
                `UCR_A_LSR:
                begin
                    // status location otherwise: write dropped
                    if (mode == ucr_pkg::ucr_mode_enhanced)
                        ctrl_r.xon2 <= wdata;
                end
                `UCR_A_MSR:
                begin
                    if (mode == ucr_pkg::ucr_mode_enhanced)
                        ctrl_r.xoff1 <= wdata;
                end
                `UCR_A_SPR:
                begin
                    if (mode == ucr_pkg::ucr_mode_enhanced)
                        ctrl_r.xoff2 <= wdata;
                    else if (ctrl_r.feature_control[`UCR_FEATURE_CONTROL_SWAP])
                        ctrl_r.enhanced_mode_select <= wdata;
                    else
                        spr_r <= wdata;
                end
                default:
                    ctrl_r <= ctrl_r;
            endcase
        end
    end

    // ****************************************************************
    // write side effects
    // ****************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            tx_load_r       <= 1'b0;
            tx_data_r       <= `UCR_RST_ZERO;
            rx_fifo_reset_r <= 1'b0;
            tx_fifo_reset_r <= 1'b0;
        end
        else
        begin
            tx_load_r       <= wr && (addr == `UCR_A_DATA)
                               && (mode == ucr_pkg::ucr_mode_normal);
            rx_fifo_reset_r <= wr && (addr == `UCR_A_ISR) && (mode == ucr_pkg::ucr_mode_normal)
                               && wdata[`UCR_FCR_RXRST];
            tx_fifo_reset_r <= wr && (addr == `UCR_A_ISR) && (mode == ucr_pkg::ucr_mode_normal)
                               && wdata[`UCR_FCR_TXRST];
            if (wr && (addr == `UCR_A_DATA) && (mode == ucr_pkg::ucr_mode_normal))
                tx_data_r <= wdata;
        end
    end

    // ****************************************************************
    // status capture
    // ****************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            lsr_r <= `UCR_RST_LSR;
            isr_r <= `UCR_RST_ISR;
            lvl_r <= `UCR_RST_ZERO;
        end
        else
        begin
            lsr_r <= engine_i.line_status;
            isr_r <= {{2{ctrl_r.fifo_control[`UCR_FCR_EN]}}, engine_i.int_code};
            lvl_r <= engine_i.fifo_level;
        end
    end

    // change flags: a change in the read cycle survives the clear
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            msr_prev_r   <= 4'h0;
            msr_primed_r <= 1'b0;
            msr_delta_r  <= 4'h0;
        end
        else
        begin
            msr_prev_r   <= msr_now;
            msr_primed_r <= 1'b1;
            if (rd && (addr == `UCR_A_MSR) && (mode != ucr_pkg::ucr_mode_enhanced))
                msr_delta_r <= msr_primed_r ? (msr_now ^ msr_prev_r) : 4'h0;
            else if (msr_primed_r)
                msr_delta_r <= msr_delta_r | (msr_now ^ msr_prev_r);
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb
    begin
        rd_mux = `UCR_RST_ZERO;
        case (addr)
            `UCR_A_DATA:
                if (mode == ucr_pkg::ucr_mode_enhanced)
                    rd_mux = lvl_r;
                else if (mode == ucr_pkg::ucr_mode_divisor)
                    rd_mux = div_zero ? REVISION_ID : ctrl_r.dll;
                else
                    rd_mux = engine_i.rx_data;
            `UCR_A_IER:
                if (mode == ucr_pkg::ucr_mode_enhanced)
                    rd_mux = ctrl_r.feature_control;
                else if (mode == ucr_pkg::ucr_mode_divisor)
                    rd_mux = div_zero ? DEVICE_ID : ctrl_r.divisor_high;
                else
                    rd_mux = ucr_mask(ctrl_r.interrupt_enable, `UCR_GATE_IER, gate_open);
            `UCR_A_ISR:
                if (mode == ucr_pkg::ucr_mode_enhanced)
                    rd_mux = ctrl_r.enhanced_function;
                else if (mode == ucr_pkg::ucr_mode_divisor)
                    rd_mux = ctrl_r.alt_function;
                else
                    rd_mux = ucr_mask(isr_r, `UCR_GATE_ISR, gate_open);
            `UCR_A_LCR:
                rd_mux = ctrl_r.line_control;
            `UCR_A_MCR:
                if (mode == ucr_pkg::ucr_mode_enhanced)
                    rd_mux = ctrl_r.xon1;
                else
                    rd_mux = ucr_mask(ctrl_r.modem_control, `UCR_GATE_MCR, gate_open);
            `UCR_A_LSR:
                rd_mux = (mode == ucr_pkg::ucr_mode_enhanced) ? ctrl_r.xon2 : lsr_r;
            `UCR_A_MSR:
                rd_mux = (mode == ucr_pkg::ucr_mode_enhanced) ? ctrl_r.xoff1
                                                              : {msr_now, msr_delta_r};
            `UCR_A_SPR:
                if (mode == ucr_pkg::ucr_mode_enhanced)
                    rd_mux = ctrl_r.xoff2;
                else if (ctrl_r.feature_control[`UCR_FEATURE_CONTROL_SWAP])
                    rd_mux = lvl_r;
                else
                    rd_mux = spr_r;
            default:
                rd_mux = `UCR_RST_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            rd_data_r  <= `UCR_RST_ZERO;
            rd_valid_r <= 1'b0;
            rx_take_r  <= 1'b0;
        end
        else
        begin
            rd_valid_r <= rd;
            rx_take_r  <= rd && (addr == `UCR_A_DATA)
                          && (mode == ucr_pkg::ucr_mode_normal);
            if (rd)
                rd_data_r <= rd_mux;
        end
    end

    // ****************************************************************
    // baud tick: one pulse every divisor clocks, idle while divisor is zero
    // ****************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || div_zero)
        begin
            baud_cnt_r  <= 16'h0000;
            baud_tick_r <= 1'b0;
        end
        else if (baud_cnt_r >= div_word - 16'h0001)
        begin
            baud_cnt_r  <= 16'h0000;
            baud_tick_r <= 1'b1;
        end
        else
        begin
            baud_cnt_r  <= baud_cnt_r + 16'h0001;
            baud_tick_r <= 1'b0;
        end
    end

    assign rd_data_o       = rd_data_r;
    assign rd_valid_o      = rd_valid_r;
    assign ctrl_o          = ctrl_r;
    assign tx_load_o       = tx_load_r;
    assign tx_data_o       = tx_data_r;
    assign rx_take_o       = rx_take_r;
    assign rx_fifo_reset_o = rx_fifo_reset_r;
    assign tx_fifo_reset_o = tx_fifo_reset_r;
    assign baud_tick_o     = baud_tick_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    a_tx_holding_load: assert property (
        wr && addr == `UCR_A_DATA && mode == ucr_pkg::ucr_mode_normal
        |=> tx_load_o && tx_data_o == $past(wdata) ##1 !tx_load_o || $past(wr))
        else $error("tx holding write not passed on");

    a_divisor_low_write: assert property (
        wr && addr == `UCR_A_DATA && mode == ucr_pkg::ucr_mode_divisor
        |=> ctrl_o.dll == $past(wdata) && !tx_load_o)
        else $error("divisor low write wrong");

    a_ident_code_read: assert property (
        rd && addr == `UCR_A_IER && mode == ucr_pkg::ucr_mode_divisor && div_zero
        |=> rd_valid_o && rd_data_o == DEVICE_ID)
        else $error("device code not returned");

    a_ier_gate_shut: assert property (
        wr && addr == `UCR_A_IER && mode == ucr_pkg::ucr_mode_normal && !gate_open
        |=> ctrl_o.interrupt_enable[7:4] == $past(ctrl_o.interrupt_enable[7:4]) && ctrl_o.interrupt_enable[3:0] == $past(wdata[3:0]))
        else $error("gated enable bits changed");

    a_lcr_any_mode: assert property (
        wr && addr == `UCR_A_LCR |=> ctrl_o.line_control == $past(wdata))
        else $error("line control not written");

    a_status_read_safe: assert property (
        rd && !wr |=> ctrl_o == $past(ctrl_o))
        else $error("read changed control state");

    a_lsr_write_dropped: assert property (
        wr && addr == `UCR_A_LSR && mode != ucr_pkg::ucr_mode_enhanced
        |=> ctrl_o == $past(ctrl_o) && spr_r == $past(spr_r))
        else $error("status write changed state");

    a_msr_delta_clear: assert property (
        rd && addr == `UCR_A_MSR && mode != ucr_pkg::ucr_mode_enhanced
        && msr_now == msr_prev_r ##1 $stable(msr_now) |-> msr_delta_r == 4'h0)
        else $error("change flags not cleared by read");

    a_baud_gap: assert property (
        baud_tick_o && div_word >= 16'h0002 && $stable(div_word) |=> !baud_tick_o)
        else $error("baud tick too early");

    a_baud_period_two: assert property (
        baud_tick_o && div_word == 16'h0002 ##1 div_word == 16'h0002 |=> baud_tick_o)
        else $error("baud period wrong");

    c_enhanced_char: cover property (
        wr && addr == `UCR_A_SPR && mode == ucr_pkg::ucr_mode_enhanced);
    c_revision_read: cover property (
        rd && addr == `UCR_A_DATA && mode == ucr_pkg::ucr_mode_divisor && div_zero);
    c_msr_change: cover property (msr_delta_r != 4'h0 ##1 msr_delta_r == 4'h0);
    c_baud_ticks: cover property (baud_tick_o ##2 baud_tick_o);

endmodule

`default_nettype wire

// ---- design/ucr_pkg.sv ----
package ucr_pkg;

    // one host access cycle; rd and wr are one-cycle strobes
    typedef struct packed {
        logic       cs;
        logic       chan;
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ucr_host_req_t;

    // state reported by the serial engine
    typedef struct packed {
        logic [7:0] rx_data;
        logic [7:0] line_status;
        logic [7:0] fifo_level;
        logic [5:0] int_code;
        logic       cts;
        logic       dsr;
        logic       ri;
        logic       cd;
    } ucr_engine_t;

    // control registers handed to the serial engine
    typedef struct packed {
        logic [7:0] interrupt_enable;
        logic [7:0] fifo_control;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] dll;
        logic [7:0] divisor_high;
        logic [7:0] alt_function;
        logic [7:0] enhanced_function;
        logic [7:0] feature_control;
        logic [7:0] enhanced_mode_select;
        logic [7:0] trigger_level_set;
        logic [7:0] xon1;
        logic [7:0] xon2;
        logic [7:0] xoff1;
        logic [7:0] xoff2;
    } ucr_ctrl_t;

    typedef enum logic [1:0] {
        ucr_mode_normal,
        ucr_mode_divisor,
        ucr_mode_enhanced
    } ucr_mode_t;

endpackage
